// [inc/rfc_pkg.sv]
// Constants and operation codes of the register and flag core
package rfc_pkg;
	// ==========================================================
	// Reset values
	localparam logic [13:0] IP_RST   = 14'h3ffd;
	localparam logic [13:0] LINK_RST = 14'h3ffd;
	localparam logic [7:0]  ACC_RST  = 8'h00;
	localparam logic [7:0]  PTR_RST  = 8'h00;
	localparam logic [7:0]  PAGE_RST = 8'h00;
	// ==========================================================
	// Memory-mapped address generation registers
	localparam logic [13:0] ADDR_DATA_PORT = 14'h000e;
	localparam logic [13:0] ADDR_POINTER   = 14'h000f;
	localparam logic [13:0] ADDR_PAGE_SEL  = 14'h001f;
	localparam logic [13:0] WIN_LO         = 14'h00c0;
	localparam logic [13:0] WIN_HI         = 14'h00ff;
	localparam logic [7:0]  MSB_LIMIT      = 8'h80;
	// ==========================================================
	// Operand addressing forms
	typedef enum logic [1:0] {
		RFC_EA_TINY   = 2'h0,
		RFC_EA_SHORT  = 2'h1,
		RFC_EA_DIRECT = 2'h2,
		RFC_EA_INDEX  = 2'h3
	} rfc_ea_e;
	// ==========================================================
	// Operations presented by the sequencer
	typedef enum logic [5:0] {
		RFC_NOP  = 6'h00, RFC_LDA  = 6'h01, RFC_STA  = 6'h02,
		RFC_ADD  = 6'h03, RFC_SUB  = 6'h04, RFC_CMP  = 6'h05,
		RFC_AND  = 6'h06, RFC_ORA  = 6'h07, RFC_EOR  = 6'h08,
		RFC_LSL  = 6'h09, RFC_LSR  = 6'h0a, RFC_ROL  = 6'h0b,
		RFC_ROR  = 6'h0c, RFC_INC  = 6'h0d, RFC_DEC  = 6'h0e,
		RFC_CARRY_FORCE_ONE_OP        = 6'h0f,
		RFC_CARRY_FORCE_ZERO_OP       = 6'h10,
		RFC_TEST_BIT_SET_BRANCH       = 6'h11,
		RFC_TEST_BIT_CLEAR_BRANCH     = 6'h12,
		RFC_BRANCH_ON_EQUAL           = 6'h13,
		RFC_BRANCH_ON_UNEQUAL         = 6'h14,
		RFC_BRANCH_ON_NO_CARRY        = 6'h15,
		RFC_BRANCH_ON_CARRY           = 6'h16,
		RFC_BRA  = 6'h17, RFC_JMP  = 6'h18,
		RFC_JUMP_TO_SUBROUTINE_OP     = 6'h19,
		RFC_BRANCH_TO_SUBROUTINE_OP   = 6'h1a,
		RFC_RTS  = 6'h1b, RFC_SHA  = 6'h1c,
		RFC_SWAP_ACC_WITH_LOWER_LINK  = 6'h1d,
		RFC_MOV  = 6'h1e,
		RFC_DECREMENT_LOOP_BRANCH     = 6'h1f
	} rfc_op_e;
endpackage : rfc_pkg

// [inc/rfc_alu_if.sv]
// Operand and result bundle between core and arithmetic unit
`timescale 1ns/1ps
interface rfc_alu_if;
	rfc_pkg::rfc_op_e op;
	logic [7:0]       a;
	logic [7:0]       m;
	logic             cin;
	logic [7:0]       res;
	logic             z;
	logic             c;
	logic             z_upd;
	logic             c_upd;
	modport core (output op, a, m, cin,
		input res, z, c, z_upd, c_upd);
	modport alu (input op, a, m, cin,
		output res, z, c, z_upd, c_upd);
endinterface : rfc_alu_if

// [core/rfc_alu.sv]
// Combinational arithmetic, logic, shift and flag unit
`timescale 1ns/1ps
module rfc_alu (
	// Operands and results
	rfc_alu_if.alu u
);
	logic [8:0] sum;

	always_comb begin
		sum     = 9'h000;
		u.res   = u.a;
		u.c     = u.cin;
		u.z_upd = 1'b1;
		u.c_upd = 1'b0;
		case (u.op)
			rfc_pkg::RFC_LDA, rfc_pkg::RFC_MOV: begin
				u.res = u.m;
			end
			rfc_pkg::RFC_STA: begin
				u.res = u.a;
			end
			// RULE11 add carry
			rfc_pkg::RFC_ADD: begin
				u.res   = u.a + u.m;
				u.c_upd = 1'b1;
				u.c = (u.a[7] & u.m[7]) | (u.a[7] & ~u.res[7])
					| (u.m[7] & ~u.res[7]);
			end
			// RULE12 borrow on subtract
			rfc_pkg::RFC_SUB, rfc_pkg::RFC_CMP: begin
				sum     = {1'b0, u.a} - {1'b0, u.m};
				u.res   = sum[7:0];
				u.c_upd = 1'b1;
				u.c     = (u.m > u.a);
			end
			rfc_pkg::RFC_AND: u.res = u.a & u.m;
			rfc_pkg::RFC_ORA: u.res = u.a | u.m;
			rfc_pkg::RFC_EOR: u.res = u.a ^ u.m;
			// RULE16 logical shifts
			rfc_pkg::RFC_LSL: begin
				u.res   = {u.a[6:0], 1'b0};
				u.c     = u.a[7];
				u.c_upd = 1'b1;
			end
			rfc_pkg::RFC_LSR: begin
				u.res   = {1'b0, u.a[7:1]};
				u.c     = u.a[0];
				u.c_upd = 1'b1;
			end
			// RULE17 rotate through carry
			rfc_pkg::RFC_ROL: begin
				u.res   = {u.a[6:0], u.cin};
				u.c     = u.a[7];
				u.c_upd = 1'b1;
			end
			rfc_pkg::RFC_ROR: begin
				u.res   = {u.cin, u.a[7:1]};
				u.c     = u.a[0];
				u.c_upd = 1'b1;
			end
			rfc_pkg::RFC_INC: u.res = u.a + 8'h01;
			rfc_pkg::RFC_DEC: u.res = u.a - 8'h01;
			default: begin
				u.z_upd = 1'b0;
			end
		endcase
		// RULE10 zero from result
		u.z = (u.res == 8'h00);
	end
endmodule : rfc_alu

// [core/rfc_core.sv]
// Accumulator, pointers, flag pair and address generation core
// Summary of operation
// RULE1: Reset clears the accumulator to zero.
// RULE2: Instruction pointer is a 14-bit register of the next fetch.
// RULE3: Pointer steps per fetched byte; jumps, branches, returns load targets.
// RULE4: Reset loads instruction pointer with 3ffd.
// RULE5: Subroutine calls store the return address in the 14-bit link.
// RULE6: Subroutine return copies the link back into the pointer.
// RULE7: Reset loads the link register with 3ffd.
// RULE8: Two-bit zero and carry flags, visible only on debug port.
// RULE9: Reset clears both flags.
// RULE10: Load, store, move, arithmetic, logic, shifts set zero from result.
// RULE11: Add sets carry on unsigned overflow.
// RULE12: Subtract and compare set carry when memory exceeds register.
// RULE13: Only add, subtract, compare, shift, rotate, bit tests and carry forcing touch carry; others keep it.
// RULE14: Bit-test branches copy the tested bit into carry.
// RULE15: Dedicated operations force carry to one or zero.
// RULE16: Logical shift leaves the shifted-out bit in carry.
// RULE17: Rotate takes old carry in and the outgoing bit into carry.
// RULE18: Each flag branch tests exactly one flag; bit-test and loop branches test the memory byte.
// RULE19: Data port, pointer, page select decode at 000e, 000f, 001f.
// RULE20: Exchange accumulator with link upper or lower part.
// RULE21: Accumulator operations write their result to the accumulator.
// RULE22: Moves and loop decrement leave the accumulator untouched.
// RULE23: Taken relative branch adds sign-extended offset to pointer.
// RULE24: Tiny form pads a 4-bit address with ten zeros.
// RULE25: Short form pads a 5-bit address with nine zeros.
// RULE26: Flags stay stable across operations that do not name them.
`timescale 1ns/1ps
module rfc_core (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             nrst,
	// Operation from the sequencer
	input  wire logic             op_valid,
	input  wire rfc_pkg::rfc_op_e op_kind,
	input  wire logic [7:0]       op_mem,
	input  wire logic [2:0]       op_bit,
	input  wire logic [7:0]       op_offset,
	input  wire logic [13:0]      op_target,
	input  wire logic             fetch_step,
	// Operand address request
	input  wire logic             ea_req,
	input  wire rfc_pkg::rfc_ea_e ea_mode,
	input  wire logic [7:0]       ea_field,
	// Mapped register access
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [13:0]      reg_addr,
	input  wire logic [7:0]       reg_wdata,
	// State and results
	output logic [7:0]            acc_out,
	output logic [13:0]           ip_out,
	output logic [13:0]           link_out,
	output logic [1:0]            dbg_flags,
	output logic [13:0]           ea_out,
	output logic                  mem_we,
	output logic [7:0]            mem_wdata,
	output logic [7:0]            reg_rdata,
	output logic                  reg_hit
);
	// ==========================================================
	// Storage
	logic [7:0]  acc_reg;
	logic [13:0] ip_reg;
	logic [13:0] link_reg;
	logic        zf_reg;
	logic        cf_reg;
	logic [7:0]  ptr_reg;
	logic [7:0]  page_reg;
	logic [13:0] ea_reg;
	logic        we_reg;
	logic [7:0]  wd_reg;
	logic [7:0]  rd_reg;
	logic        hit_reg;

	rfc_alu_if alu_b ();

	rfc_alu u_alu (
		.u (alu_b.alu)
	);

	assign alu_b.op  = op_valid ? op_kind : rfc_pkg::RFC_NOP;
	assign alu_b.a   = acc_reg;
	assign alu_b.m   = op_mem;
	assign alu_b.cin = cf_reg;

	// ==========================================================
	// Branch decision
	logic        tbit;
	logic        taken;
	logic        flow;
	logic [7:0]  dec_m;
	logic [13:0] rel_next;

	assign tbit  = op_mem[op_bit];
	assign dec_m = op_mem - 8'h01;
	// RULE23 sign-extended offset
	assign rel_next = ip_reg + {{6{op_offset[7]}}, op_offset};

	always_comb begin
		taken = 1'b0;
		flow  = 1'b0;
		if (op_valid) begin
			// RULE18 one flag per branch
			case (op_kind)
				rfc_pkg::RFC_BRANCH_ON_EQUAL:
					taken = zf_reg;
				rfc_pkg::RFC_BRANCH_ON_UNEQUAL:
					taken = ~zf_reg;
				rfc_pkg::RFC_BRANCH_ON_NO_CARRY:
					taken = ~cf_reg;
				rfc_pkg::RFC_BRANCH_ON_CARRY:
					taken = cf_reg;
				rfc_pkg::RFC_TEST_BIT_SET_BRANCH:
					taken = tbit;
				rfc_pkg::RFC_TEST_BIT_CLEAR_BRANCH:
					taken = ~tbit;
				rfc_pkg::RFC_DECREMENT_LOOP_BRANCH:
					taken = (dec_m != 8'h00);
				rfc_pkg::RFC_BRA:
					taken = 1'b1;
				rfc_pkg::RFC_BRANCH_TO_SUBROUTINE_OP:
					taken = 1'b1;
				default:
					taken = 1'b0;
			endcase
			flow = taken || op_kind == rfc_pkg::RFC_JMP
				|| op_kind == rfc_pkg::RFC_JUMP_TO_SUBROUTINE_OP
				|| op_kind == rfc_pkg::RFC_RTS;
		end
	end

	// ==========================================================
	// Instruction pointer
	// RULE4 reset location
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ip_reg <= rfc_pkg::IP_RST;
		end else if (flow) begin
			// RULE3 change of flow wins over stepping
			case (op_kind)
				rfc_pkg::RFC_JMP,
				rfc_pkg::RFC_JUMP_TO_SUBROUTINE_OP: begin
					ip_reg <= op_target;
				end
				// RULE6 return from link
				rfc_pkg::RFC_RTS: ip_reg <= link_reg;
				default:          ip_reg <= rel_next;
			endcase
		end else if (fetch_step) begin
			// RULE2 sequential fetch
			ip_reg <= ip_reg + 14'h0001;
		end
	end

	// ==========================================================
	// Return link
	// RULE7 reset location
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			link_reg <= rfc_pkg::LINK_RST;
		end else if (op_valid) begin
			case (op_kind)
				// RULE5 save return address
				rfc_pkg::RFC_JUMP_TO_SUBROUTINE_OP,
				rfc_pkg::RFC_BRANCH_TO_SUBROUTINE_OP: begin
					link_reg <= ip_reg;
				end
				// RULE20 exchange with link parts
				rfc_pkg::RFC_SHA: link_reg[13:8] <= acc_reg[5:0];
				rfc_pkg::RFC_SWAP_ACC_WITH_LOWER_LINK: begin
					link_reg[7:0] <= acc_reg;
				end
				default:          link_reg <= link_reg;
			endcase
		end
	end

	// ==========================================================
	// Accumulator
	// RULE1 reset clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			acc_reg <= rfc_pkg::ACC_RST;
		end else if (op_valid) begin
			case (op_kind)
				// RULE21 result into accumulator
				rfc_pkg::RFC_LDA, rfc_pkg::RFC_ADD,
				rfc_pkg::RFC_SUB, rfc_pkg::RFC_AND,
				rfc_pkg::RFC_ORA, rfc_pkg::RFC_EOR,
				rfc_pkg::RFC_LSL, rfc_pkg::RFC_LSR,
				rfc_pkg::RFC_ROL, rfc_pkg::RFC_ROR,
				rfc_pkg::RFC_INC, rfc_pkg::RFC_DEC: begin
					acc_reg <= alu_b.res;
				end
				// RULE20 exchange with link parts
				rfc_pkg::RFC_SHA: acc_reg <= {2'b00, link_reg[13:8]};
				rfc_pkg::RFC_SWAP_ACC_WITH_LOWER_LINK: begin
					acc_reg <= link_reg[7:0];
				end
				// RULE22 moves leave accumulator
				default:          acc_reg <= acc_reg;
			endcase
		end
	end

	// ==========================================================
	// Flag pair
	// RULE9 reset clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			zf_reg <= 1'b0;
			cf_reg <= 1'b0;
		end else if (op_valid) begin
			// RULE26 unnamed ops keep both flags
			// RULE10 zero update
			if (alu_b.z_upd) begin
				zf_reg <= alu_b.z;
			end
			// RULE13 carry only from its groups
			if (alu_b.c_upd) begin
				cf_reg <= alu_b.c;
			end
			// RULE14 tested bit into carry
			if (op_kind == rfc_pkg::RFC_TEST_BIT_SET_BRANCH
				|| op_kind == rfc_pkg::RFC_TEST_BIT_CLEAR_BRANCH) begin
				cf_reg <= tbit;
			end
			// RULE15 forced carry
			if (op_kind == rfc_pkg::RFC_CARRY_FORCE_ONE_OP) begin
				cf_reg <= 1'b1;
			end
			if (op_kind == rfc_pkg::RFC_CARRY_FORCE_ZERO_OP) begin
				cf_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Memory write-back for store, move and loop decrement
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			we_reg <= 1'b0;
			wd_reg <= 8'h00;
		end else begin
			we_reg <= 1'b0;
			if (op_valid) begin
				case (op_kind)
					rfc_pkg::RFC_STA: begin
						we_reg <= 1'b1;
						wd_reg <= acc_reg;
					end
					// RULE22 memory-only operations
					rfc_pkg::RFC_MOV: begin
						we_reg <= 1'b1;
						wd_reg <= op_mem;
					end
					rfc_pkg::RFC_DECREMENT_LOOP_BRANCH: begin
						we_reg <= 1'b1;
						wd_reg <= dec_m;
					end
					default: we_reg <= 1'b0;
				endcase
			end
		end
	end

	// ==========================================================
	// Address generation
	logic [13:0] ea_raw;
	logic [13:0] ea_next;

	always_comb begin
		case (ea_mode)
			// RULE24 tiny form
			rfc_pkg::RFC_EA_TINY:  ea_raw = {10'h000, ea_field[3:0]};
			// RULE25 short form
			rfc_pkg::RFC_EA_SHORT: ea_raw = {9'h000, ea_field[4:0]};
			rfc_pkg::RFC_EA_INDEX: ea_raw = {6'h00, ptr_reg};
			default:               ea_raw = {6'h00, ea_field};
		endcase
		ea_next = ea_raw;
		// RULE19 data port reaches the pointed byte
		if (ea_raw == rfc_pkg::ADDR_DATA_PORT) begin
			ea_next = {6'h00, ptr_reg};
		end
		// Window is applied after indexing, so the data port pages too
		if (ea_next >= rfc_pkg::WIN_LO && ea_next <= rfc_pkg::WIN_HI) begin
			ea_next = {page_reg, ea_next[5:0]};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ea_reg <= 14'h0000;
		end else if (ea_req) begin
			ea_reg <= ea_next;
		end
	end

	// ==========================================================
	// Mapped pointer and page select
	// RULE19 register decode
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ptr_reg  <= rfc_pkg::PTR_RST;
			page_reg <= rfc_pkg::PAGE_RST;
		end else if (reg_wr) begin
			if (reg_addr == rfc_pkg::ADDR_POINTER) begin
				ptr_reg <= reg_wdata;
			end
			if (reg_addr == rfc_pkg::ADDR_PAGE_SEL) begin
				page_reg <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_reg  <= 8'h00;
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= 1'b0;
			rd_reg  <= 8'h00;
			if (reg_rd && reg_addr == rfc_pkg::ADDR_POINTER) begin
				hit_reg <= 1'b1;
				rd_reg  <= ptr_reg;
			end
			if (reg_rd && reg_addr == rfc_pkg::ADDR_PAGE_SEL) begin
				hit_reg <= 1'b1;
				rd_reg  <= page_reg;
			end
		end
	end

	// RULE8 flags only on debug port
	assign dbg_flags = {zf_reg, cf_reg};
	assign acc_out   = acc_reg;
	assign ip_out    = ip_reg;
	assign link_out  = link_reg;
	assign ea_out    = ea_reg;
	assign mem_we    = we_reg;
	assign mem_wdata = wd_reg;
	assign reg_rdata = rd_reg;
	assign reg_hit   = hit_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_ip_return: assert property ( // RULE6
		op_valid && op_kind == rfc_pkg::RFC_RTS
		|=> ip_reg == $past(link_reg))
		else $error("return did not restore pointer");
	a_link_save: assert property ( // RULE5
		op_valid && op_kind == rfc_pkg::RFC_JUMP_TO_SUBROUTINE_OP
		|=> link_reg == $past(ip_reg) && ip_reg == $past(op_target))
		else $error("call did not save return address");
	a_ip_step: assert property ( // RULE3
		fetch_step && !flow |=> ip_reg == $past(ip_reg) + 14'h0001)
		else $error("pointer did not step");
	a_rel_branch: assert property ( // RULE23
		op_valid && op_kind == rfc_pkg::RFC_BRA
		|=> ip_reg == $past(rel_next))
		else $error("relative branch target wrong");
	a_carry_hold: assert property ( // RULE13
		!(op_valid && (alu_b.c_upd
		|| op_kind == rfc_pkg::RFC_CARRY_FORCE_ONE_OP
		|| op_kind == rfc_pkg::RFC_CARRY_FORCE_ZERO_OP
		|| op_kind == rfc_pkg::RFC_TEST_BIT_SET_BRANCH
		|| op_kind == rfc_pkg::RFC_TEST_BIT_CLEAR_BRANCH))
		|=> $stable(cf_reg))
		else $error("carry changed unexpectedly");
	a_add_carry: assert property ( // RULE11
		op_valid && op_kind == rfc_pkg::RFC_ADD
		|=> cf_reg == ($past({1'b0, acc_reg}) + $past({1'b0, op_mem})
		> 9'h0ff))
		else $error("add carry wrong");
	a_sub_borrow: assert property ( // RULE12
		op_valid && op_kind == rfc_pkg::RFC_CMP
		|=> cf_reg == ($past(op_mem) > $past(acc_reg))
		&& $stable(acc_reg))
		else $error("compare borrow wrong");
	a_zero_load: assert property ( // RULE10
		op_valid && op_kind == rfc_pkg::RFC_LDA
		|=> zf_reg == (acc_reg == 8'h00))
		else $error("zero flag wrong after load");
	a_bit_copy: assert property ( // RULE14
		op_valid && op_kind == rfc_pkg::RFC_TEST_BIT_CLEAR_BRANCH
		|=> cf_reg == $past(tbit))
		else $error("bit test carry wrong");
	a_move_acc: assert property ( // RULE22
		op_valid && op_kind == rfc_pkg::RFC_MOV |=> $stable(acc_reg)
		##0 mem_we && mem_wdata == $past(op_mem))
		else $error("move touched accumulator");
	a_flag_idle: assert property ( // RULE26
		!op_valid [*2] |=> $stable(zf_reg) && $stable(cf_reg))
		else $error("flags drifted while idle");

	c_call_ret: cover property (op_valid
		&& op_kind == rfc_pkg::RFC_JUMP_TO_SUBROUTINE_OP
		##[1:20] op_valid && op_kind == rfc_pkg::RFC_RTS);
	c_page_win: cover property (ea_req && ea_next[13:6] == page_reg
		&& page_reg != 8'h00);
	c_add_ovf: cover property (op_valid && op_kind == rfc_pkg::RFC_ADD
		&& alu_b.c);
endmodule : rfc_core

// [bench/rfc_mem_model.sv]
// Behavioural data memory standing behind the core's store port
`timescale 1ns/1ps
module rfc_mem_model (
	// Clock
	input  wire logic        core_clk,
	// Store port and read view
	input  wire logic        we,
	input  wire logic [13:0] addr,
	input  wire logic [7:0]  wdata,
	output logic [7:0]       rdata
);
	// ==========================================================
	// Storage
	// Direct page only: the bench never stores above 00ff
	logic [7:0] mem [0:255];

	always_ff @(posedge core_clk) begin
		if (we)
			mem[addr[7:0]] <= wdata;
	end

	// Unwritten bytes read as unknown, so a missed store never matches
	assign rdata = mem[addr[7:0]];
endmodule : rfc_mem_model

// [bench/testbench.sv]
// Self-checking bench of the register and flag core
`timescale 1ns/1ps
module testbench;
	logic             core_clk, nrst, op_valid, fetch_step, ea_req;
	logic             reg_wr, reg_rd, mem_we, reg_hit;
	rfc_pkg::rfc_op_e op_kind;
	rfc_pkg::rfc_ea_e ea_mode;
	logic [7:0]       op_mem, op_offset, ea_field, reg_wdata;
	logic [7:0]       acc_out, mem_wdata, reg_rdata, mem_rdata;
	logic [2:0]       op_bit;
	logic [13:0]      op_target, reg_addr, ip_out, link_out, ea_out;
	logic [1:0]       dbg_flags;
	int               fail_count, checked;

	rfc_core i_rfc_core (.core_clk(core_clk), .nrst(nrst),
		.op_valid(op_valid), .op_kind(op_kind), .op_mem(op_mem),
		.op_bit(op_bit), .op_offset(op_offset), .op_target(op_target),
		.fetch_step(fetch_step), .ea_req(ea_req), .ea_mode(ea_mode),
		.ea_field(ea_field), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .acc_out(acc_out),
		.ip_out(ip_out), .link_out(link_out), .dbg_flags(dbg_flags),
		.ea_out(ea_out), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit));
	rfc_mem_model i_rfc_mem_model (.core_clk(core_clk), .we(mem_we),
		.addr(ea_out), .wdata(mem_wdata), .rdata(mem_rdata));

	always #10 core_clk = ~core_clk;

	// ==========================================================
	// Checking and closing
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// ==========================================================
	// Access tasks, all entered and left at a falling edge
	// Valid stays high between ops so it never toggles in one step
	task automatic op(input rfc_pkg::rfc_op_e k, input logic [7:0] m);
		op_kind = k;
		op_mem = m;
		op_valid = 1'b1;
		@(negedge core_clk);
	endtask : op

	task automatic reg_write(input logic [13:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		@(negedge core_clk);
	endtask : reg_write

	task automatic reg_read(input logic [13:0] a, input logic [7:0] d,
		input logic h);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		chk("reg_hit", 16'(reg_hit), 16'(h));
		chk("reg_rdata", 16'(reg_rdata), 16'(d));
		reg_rd = 1'b0;
		@(negedge core_clk);
	endtask : reg_read

	task automatic ea(input rfc_pkg::rfc_ea_e md, input logic [7:0] f,
		input logic [13:0] e);
		ea_mode = md;
		ea_field = f;
		ea_req = 1'b1;
		@(negedge core_clk);
		ea_req = 1'b0;
		@(negedge core_clk);
		chk("ea_out", 16'(ea_out), 16'(e));
	endtask : ea

	task automatic st(input logic [7:0] a, input logic [13:0] p,
		input logic [1:0] f);
		chk("acc", 16'(acc_out), 16'(a));
		chk("ip", 16'(ip_out), 16'(p));
		chk("flags", 16'(dbg_flags), 16'(f));
	endtask : st

	// Hang guard, roughly 100000 cycles
	initial begin
		#2000000;
		fail_count++;
		conclude();
	end

	// ==========================================================
	// Main sequence
	initial begin
		core_clk = 0; nrst = 0; op_valid = 0; fetch_step = 0;
		ea_req = 0; reg_wr = 0; reg_rd = 0; op_kind = rfc_pkg::RFC_NOP;
		ea_mode = rfc_pkg::RFC_EA_TINY; op_mem = 0; op_offset = 0;
		ea_field = 0; reg_wdata = 0; op_bit = 0; op_target = 0;
		reg_addr = 0; fail_count = 0; checked = 0;
		repeat (20) @(negedge core_clk);
		nrst = 1;
		st(8'h00, 14'h3ffd, 2'b00);
		chk("link", 16'(link_out), 16'h3ffd);
		reg_read(14'h000f, 8'h00, 1'b1);
		reg_read(14'h0010, 8'h00, 1'b0);
		reg_write(14'h000f, 8'h42);
		reg_write(14'h001f, 8'h12);
		reg_read(14'h000f, 8'h42, 1'b1);
		reg_read(14'h001f, 8'h12, 1'b1);
		ea(rfc_pkg::RFC_EA_TINY, 8'h35, 14'h0005);
		ea(rfc_pkg::RFC_EA_SHORT, 8'h35, 14'h0015);
		ea(rfc_pkg::RFC_EA_TINY, 8'h0e, 14'h0042);
		ea(rfc_pkg::RFC_EA_INDEX, 8'h00, 14'h0042);
		ea(rfc_pkg::RFC_EA_DIRECT, 8'hc5, 14'h0485);
		fetch_step = 1;
		@(negedge core_clk);
		fetch_step = 0;
		@(negedge core_clk);
		chk("ip step", 16'(ip_out), 16'h3ffe);
		// Arithmetic, logic, carry forcing; flags are {zero,carry}
		op(rfc_pkg::RFC_LDA, 8'h00); st(8'h00, 14'h3ffe, 2'b10);
		op(rfc_pkg::RFC_LDA, 8'h80); st(8'h80, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_ADD, 8'h80); st(8'h00, 14'h3ffe, 2'b11);
		op(rfc_pkg::RFC_LDA, 8'hc0); st(8'hc0, 14'h3ffe, 2'b01);
		op(rfc_pkg::RFC_ADD, 8'h50); st(8'h10, 14'h3ffe, 2'b01);
		op(rfc_pkg::RFC_ADD, 8'h01); st(8'h11, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_SUB, 8'h20); st(8'hf1, 14'h3ffe, 2'b01);
		op(rfc_pkg::RFC_CMP, 8'hf1); st(8'hf1, 14'h3ffe, 2'b10);
		op(rfc_pkg::RFC_CARRY_FORCE_ONE_OP, 8'h00);
		st(8'hf1, 14'h3ffe, 2'b11);
		op(rfc_pkg::RFC_AND, 8'h0f); st(8'h01, 14'h3ffe, 2'b01);
		op(rfc_pkg::RFC_CARRY_FORCE_ZERO_OP, 8'h00);
		st(8'h01, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_LDA, 8'h81); st(8'h81, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_LSL, 8'h00); st(8'h02, 14'h3ffe, 2'b01);
		op(rfc_pkg::RFC_ROL, 8'h00); st(8'h05, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_LSR, 8'h00); st(8'h02, 14'h3ffe, 2'b01);
		op(rfc_pkg::RFC_ROR, 8'h00); st(8'h81, 14'h3ffe, 2'b00);
		op_bit = 3'h3;
		op(rfc_pkg::RFC_TEST_BIT_SET_BRANCH, 8'h08);
		st(8'h81, 14'h3ffe, 2'b01);
		op_bit = 3'h2;
		op(rfc_pkg::RFC_TEST_BIT_CLEAR_BRANCH, 8'h08);
		st(8'h81, 14'h3ffe, 2'b00);
		// Relative branches, offset minus two, flags {0,0}
		op_offset = 8'hfe;
		op(rfc_pkg::RFC_BRANCH_ON_EQUAL, 8'h00);
		st(8'h81, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_BRANCH_ON_UNEQUAL, 8'h00);
		st(8'h81, 14'h3ffc, 2'b00);
		op(rfc_pkg::RFC_BRANCH_ON_CARRY, 8'h00);
		st(8'h81, 14'h3ffc, 2'b00);
		op(rfc_pkg::RFC_BRANCH_ON_NO_CARRY, 8'h00);
		st(8'h81, 14'h3ffa, 2'b00);
		// Calls, return and exchanges with the link
		op_target = 14'h0123;
		op(rfc_pkg::RFC_JUMP_TO_SUBROUTINE_OP, 8'h00);
		chk("link call", 16'(link_out), 16'h3ffa);
		chk("ip call", 16'(ip_out), 16'h0123);
		op(rfc_pkg::RFC_RTS, 8'h00); st(8'h81, 14'h3ffa, 2'b00);
		op_offset = 8'h04;
		op(rfc_pkg::RFC_BRANCH_TO_SUBROUTINE_OP, 8'h00);
		st(8'h81, 14'h3ffe, 2'b00);
		chk("link rel call", 16'(link_out), 16'h3ffa);
		op(rfc_pkg::RFC_SWAP_ACC_WITH_LOWER_LINK, 8'h00);
		chk("acc swap lo", 16'(acc_out), 16'h00fa);
		chk("link swap lo", 16'(link_out), 16'h3f81);
		op(rfc_pkg::RFC_SHA, 8'h00);
		chk("acc sha", 16'(acc_out), 16'h003f);
		chk("link sha", 16'(link_out), 16'h3a81);
		// Stores and moves into memory at 0007
		op_kind = rfc_pkg::RFC_NOP;
		ea(rfc_pkg::RFC_EA_SHORT, 8'h07, 14'h0007);
		op(rfc_pkg::RFC_STA, 8'h00);
		chk("we sta", 16'(mem_we), 16'h0001);
		chk("wd sta", 16'(mem_wdata), 16'h003f);
		op(rfc_pkg::RFC_MOV, 8'h55); st(8'h3f, 14'h3ffe, 2'b00);
		chk("wd mov", 16'(mem_wdata), 16'h0055);
		op(rfc_pkg::RFC_DECREMENT_LOOP_BRANCH, 8'h01);
		st(8'h3f, 14'h3ffe, 2'b00);
		chk("wd loop", 16'(mem_wdata), 16'h0000);
		op(rfc_pkg::RFC_NOP, 8'h00); st(8'h3f, 14'h3ffe, 2'b00);
		chk("mem", 16'(mem_rdata), 16'h0000);
		chk("we idle", 16'(mem_we), 16'h0000);
		// Remaining accumulator operations
		op(rfc_pkg::RFC_ORA, 8'hc0); st(8'hff, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_EOR, 8'hff); st(8'h00, 14'h3ffe, 2'b10);
		op(rfc_pkg::RFC_INC, 8'h00); st(8'h01, 14'h3ffe, 2'b00);
		op(rfc_pkg::RFC_DEC, 8'h00); st(8'h00, 14'h3ffe, 2'b10);
		conclude();
	end
endmodule : testbench
